/* design/adc_cfg_consts.vh */
// Constants for the converter configuration register bank.
// Assumes inclusion by bare name from the design file; definitions only.
// Summary of operation
// - General control at 0x1, output format 0x2, averaging 0x3, eight bits, reset zero.
// - Writing one to root_mean_square_on clears the result and restarts the computation.
// - Check-code enable appends a check code to output and verifies incoming data.
// - Statistics off freezes min, max, latest; setting it clears them, then they track.
// - Clearing window_compare_on resets and disables the window comparator; setting enables.
// - conversion_trigger is write-only and always reads zero.
// - Normally a conversion starts on the 9th falling bus clock edge; clock held low.
// - Writing conversion_trigger starts a conversion with no clock stretching.
// - force_analog_all makes every channel an analog input regardless of other settings.
// - Writing one to calibration runs offset calibration; bit self-clears when finished.
// - Software reset returns all registers to defaults, reads zero, sets power_loss_flag.
// - test_pattern_out makes every conversion data read return 0xA5A above the 4-bit tag.
// - Tag field: 00 nothing, 01 channel id, 10 status flags, 11 reserved.
// - Output format bits 6 and 3..0 are reserved, read-only, read zero.
// - power_loss_flag is set on brown-out or power cycle; host writes one to clear.
// - averaging_ratio averages two to the field value samples, 0 none, 7 gives 128.
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH
// Register indices; byte address is four times the index
`define IDX_GENERAL 6'h01
`define IDX_FORMAT 6'h02
`define IDX_AVERAGING 6'h03
`define IDX_POWER 6'h10
`define IDX_IRQ_STATUS 6'h11
`define IDX_IRQ_ENABLE 6'h12
`define IDX_IRQ_CLEAR 6'h13
`define IDX_CONV_DATA 6'h14
`define IDX_STAT_MIN 6'h15
`define IDX_STAT_MAX 6'h16
`define IDX_STAT_LATEST 6'h17
`define IDX_RMS 6'h18
// General control bit positions
`define GEN_RMS 7
`define GEN_CRC 6
`define GEN_STATS 5
`define GEN_WINDOW 4
`define GEN_TRIGGER 3
`define GEN_FORCE 2
`define GEN_CAL 1
`define GEN_SOFT_RST 0
// Output format fields
`define FMT_PATTERN 7
`define FMT_TAG_HI 5
`define FMT_TAG_LO 4
`define FMT_WRITE_MASK 8'hb0
`define AVG_WRITE_MASK 8'h07
`define TAG_NONE 2'h0
`define TAG_CHANNEL 2'h1
`define TAG_STATUS 2'h2
`define TEST_PATTERN 12'ha5a
// Reset values
`define RESET_BYTE 8'h00
`define RESET_IRQ 4'h0
// Interrupt event bit positions
`define EV_CONV 0
`define EV_CAL 1
`define EV_WINDOW 2
`define EV_CRC 3
// Timing
`define CLK_MHZ 200
`define CONV_TIME_NS 1000
`define CAL_TIME_NS 10000
`define CONV_CYCLES ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)
`define CAL_CYCLES ((`CAL_TIME_NS * `CLK_MHZ + 999) / 1000)
`define FRAME_EDGE 4'h9
`endif

/* design/adc_general_and_output_config.v */
// Register bank and conversion control for an eight-channel converter.
// Assumes a classic Wishbone master on clk, a sampled two-wire bus clock and data,
// and a converter front end that presents a 12-bit sample on the same clock.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`include "adc_cfg_consts.vh"

module adc_general_and_output_config (
   input wire clk,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire scl_i,
   input wire sda_i,
   output wire scl_o,
   output wire scl_oe,
   input wire brown_out_i,
   input wire [11:0] sample_i,
   input wire [2:0] channel_i,
   input wire [11:0] window_low_i,
   input wire [11:0] window_high_i,
   input wire crc_error_i,
   output wire crc_on,
   output wire force_analog_all,
   output reg [15:0] conv_data,
   output reg calibrate_busy,
   output wire irq
);

   // ==========================================================
   // State and storage
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_CONV = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;
   localparam integer CONV_INT = `CONV_CYCLES;
   localparam integer CAL_INT = `CAL_CYCLES;
   localparam [15:0] CONV_N = CONV_INT[15:0];
   localparam [15:0] CAL_N = CAL_INT[15:0];

   reg [7:0] general_reg;
   reg [7:0] format_reg;
   reg [7:0] averaging_reg;
   reg power_loss_flag;
   reg [3:0] irq_status_reg;
   reg [3:0] irq_enable_reg;
   reg ack_reg;
   reg soft_rst_reg;
   reg [15:0] cal_count_reg;
   reg [2:0] state_reg;
   reg [15:0] conv_count_reg;
   reg [7:0] sample_count_reg;
   reg [18:0] acc_reg;
   reg stretch_reg;
   reg [11:0] stat_min_reg;
   reg [11:0] stat_max_reg;
   reg [11:0] stat_latest_reg;
   reg stats_clear_reg;
   reg window_alarm_reg;
   reg [27:0] rms_acc_reg;
   reg [4:0] rms_count_reg;
   reg [15:0] root_mean_square_value;
   reg [11:0] result_reg;
   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg [1:0] bo_sync;
   reg scl_prev;
   reg sda_prev;
   reg [3:0] edge_count_reg;
   reg in_frame_reg;

   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire wr = bus_req & wb_we_i & wb_sel_i[0];
   wire [5:0] idx = wb_adr_i[7:2];
   wire [7:0] wbyte = wb_dat_i[7:0];
   wire wr_general = wr && (idx == `IDX_GENERAL);
   wire [2:0] averaging_ratio = averaging_reg[2:0];
   wire root_mean_square_on = general_reg[`GEN_RMS];
   wire statistics_on = general_reg[`GEN_STATS];
   wire window_compare_on = general_reg[`GEN_WINDOW];
   wire test_pattern_out = format_reg[`FMT_PATTERN];
   wire [1:0] tag_select = format_reg[`FMT_TAG_HI:`FMT_TAG_LO];

   assign wb_ack_o = ack_reg;
   assign crc_on = general_reg[`GEN_CRC];
   assign force_analog_all = general_reg[`GEN_FORCE];

   // ==========================================================
   // Pin synchronisers: first stage is read only by the second
   always @(posedge clk) begin
      if (!rst_n) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         bo_sync <= 2'b00;
      end else begin
         scl_sync <= {scl_sync[0], scl_i};
         sda_sync <= {sda_sync[0], sda_i};
         bo_sync <= {bo_sync[0], brown_out_i};
      end
   end

   // ==========================================================
   // Bus frame tracking: start condition, then count falling clock edges
   wire scl_fall = scl_prev & ~scl_sync[1];
   wire frame_start = scl_sync[1] & sda_prev & ~sda_sync[1];
   wire frame_stop = scl_sync[1] & ~sda_prev & sda_sync[1];
   wire ninth_edge = in_frame_reg & scl_fall & (edge_count_reg == `FRAME_EDGE - 4'h1);

   always @(posedge clk) begin
      if (!rst_n) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         edge_count_reg <= 4'h0;
         in_frame_reg <= 1'b0;
      end else begin
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
         if (frame_start) begin
            in_frame_reg <= 1'b1;
            edge_count_reg <= 4'h0;
         end else if (frame_stop) begin
            in_frame_reg <= 1'b0;
         end else if (ninth_edge) begin
            // Only the first acknowledge slot of a frame starts a conversion
            in_frame_reg <= 1'b0;
         end else if (in_frame_reg && scl_fall) begin
            edge_count_reg <= edge_count_reg + 4'h1;
         end
      end
   end

   // ==========================================================
   // Wishbone: registered ack one cycle after the request, acks every request, unmapped reads zero
   always @(posedge clk) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req;
      end
   end

   // Read mux registered with the ack
   always @(posedge clk) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         if (idx == `IDX_GENERAL) begin
            // Trigger and soft reset never read back
            wb_dat_o <= {24'h00_0000, general_reg & 8'hf6};
         end else if (idx == `IDX_FORMAT) begin
            wb_dat_o <= {24'h00_0000, format_reg & `FMT_WRITE_MASK};
         end else if (idx == `IDX_AVERAGING) begin
            wb_dat_o <= {24'h00_0000, averaging_reg & `AVG_WRITE_MASK};
         end else if (idx == `IDX_POWER) begin
            wb_dat_o <= {31'h0000_0000, power_loss_flag};
         end else if (idx == `IDX_IRQ_STATUS) begin
            wb_dat_o <= {28'h000_0000, irq_status_reg};
         end else if (idx == `IDX_IRQ_ENABLE) begin
            wb_dat_o <= {28'h000_0000, irq_enable_reg};
         end else if (idx == `IDX_CONV_DATA) begin
            wb_dat_o <= {16'h0000, conv_data};
         end else if (idx == `IDX_STAT_MIN) begin
            wb_dat_o <= {20'h0_0000, stat_min_reg};
         end else if (idx == `IDX_STAT_MAX) begin
            wb_dat_o <= {20'h0_0000, stat_max_reg};
         end else if (idx == `IDX_STAT_LATEST) begin
            wb_dat_o <= {20'h0_0000, stat_latest_reg};
         end else if (idx == `IDX_RMS) begin
            wb_dat_o <= {16'h0000, root_mean_square_value};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // Configuration registers; soft reset takes one cycle to apply
   wire cal_done = calibrate_busy && (cal_count_reg == CAL_N - 16'h0001);

   always @(posedge clk) begin
      if (!rst_n || soft_rst_reg) begin
         general_reg <= `RESET_BYTE;
         format_reg <= `RESET_BYTE;
         averaging_reg <= `RESET_BYTE;
         irq_enable_reg <= `RESET_IRQ;
         soft_rst_reg <= 1'b0;
      end else begin
         if (wr_general) begin
            // Trigger and reset bits are never stored
            general_reg <= wbyte & 8'hf6;
            soft_rst_reg <= wbyte[`GEN_SOFT_RST];
         end else if (cal_done) begin
            general_reg[`GEN_CAL] <= 1'b0;
         end
         if (wr && idx == `IDX_FORMAT) begin
            format_reg <= wbyte & `FMT_WRITE_MASK;
         end
         if (wr && idx == `IDX_AVERAGING) begin
            averaging_reg <= wbyte & `AVG_WRITE_MASK;
         end
         if (wr && idx == `IDX_IRQ_ENABLE) begin
            irq_enable_reg <= wbyte[3:0];
         end
      end
   end

   // Power-loss flag: set at power-up, brown-out or soft reset; set beats clear
   always @(posedge clk) begin
      if (!rst_n) begin
         power_loss_flag <= 1'b1;
      end else if (bo_sync[1] || soft_rst_reg) begin
         power_loss_flag <= 1'b1;
      end else if (wr && idx == `IDX_POWER && wbyte[0]) begin
         power_loss_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Offset calibration timer; a new write restarts it
   always @(posedge clk) begin
      if (!rst_n || soft_rst_reg) begin
         calibrate_busy <= 1'b0;
         cal_count_reg <= 16'h0000;
      end else if (wr_general && wbyte[`GEN_CAL]) begin
         calibrate_busy <= 1'b1;
         cal_count_reg <= 16'h0000;
      end else if (cal_done) begin
         calibrate_busy <= 1'b0;
      end else if (calibrate_busy) begin
         cal_count_reg <= cal_count_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Conversion sequencer with averaging over 2^ratio samples
   wire sw_trigger = wr_general & wbyte[`GEN_TRIGGER];
   wire [7:0] samples_n = 8'h01 << averaging_ratio;
   wire sample_end = (state_reg == ST_CONV) && (conv_count_reg == CONV_N - 16'h0001);
   wire [18:0] acc_sum = acc_reg + {7'h00, sample_i};
   wire [18:0] acc_avg = acc_sum >> averaging_ratio;
   wire conv_done = (state_reg == ST_DONE);

   always @(posedge clk) begin
      if (!rst_n || soft_rst_reg) begin
         state_reg <= ST_IDLE;
         conv_count_reg <= 16'h0000;
         sample_count_reg <= 8'h00;
         acc_reg <= 19'h0_0000;
         stretch_reg <= 1'b0;
         result_reg <= 12'h000;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               conv_count_reg <= 16'h0000;
               sample_count_reg <= 8'h00;
               acc_reg <= 19'h0_0000;
               if (sw_trigger) begin
                  state_reg <= ST_CONV;
                  stretch_reg <= 1'b0;
               end else if (ninth_edge) begin
                  state_reg <= ST_CONV;
                  stretch_reg <= 1'b1;
               end
            end
            ST_CONV: begin
               if (sample_end) begin
                  conv_count_reg <= 16'h0000;
                  acc_reg <= acc_sum;
                  sample_count_reg <= sample_count_reg + 8'h01;
                  if (sample_count_reg == samples_n - 8'h01) begin
                     state_reg <= ST_DONE;
                     result_reg <= acc_avg[11:0];
                  end
               end else begin
                  conv_count_reg <= conv_count_reg + 16'h0001;
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
               stretch_reg <= 1'b0;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Clock stretch: pull the bus clock low until the result is ready
   assign scl_o = 1'b0;
   assign scl_oe = stretch_reg;

   // ==========================================================
   // Output word: result or fixed pattern, plus optional 4-bit tag
   wire [11:0] out_code = test_pattern_out ? `TEST_PATTERN : result_reg;
   reg [3:0] tag_bits;

   always @* begin
      case (tag_select)
         `TAG_CHANNEL: tag_bits = {1'b0, channel_i};
         `TAG_STATUS: tag_bits = {crc_on, window_alarm_reg, calibrate_busy, power_loss_flag};
         default: tag_bits = 4'h0;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         conv_data <= 16'h0000;
      end else begin
         conv_data <= {out_code, tag_bits};
      end
   end

   // ==========================================================
   // Statistics: cleared on enable, updated on each finished result
   always @(posedge clk) begin
      if (!rst_n || soft_rst_reg) begin
         stats_clear_reg <= 1'b0;
         stat_min_reg <= 12'hfff;
         stat_max_reg <= 12'h000;
         stat_latest_reg <= 12'h000;
      end else begin
         stats_clear_reg <= wr_general & wbyte[`GEN_STATS];
         if (stats_clear_reg) begin
            stat_min_reg <= 12'hfff;
            stat_max_reg <= 12'h000;
            stat_latest_reg <= 12'h000;
         end else if (statistics_on && conv_done) begin
            stat_latest_reg <= result_reg;
            if (result_reg < stat_min_reg) begin
               stat_min_reg <= result_reg;
            end
            if (result_reg > stat_max_reg) begin
               stat_max_reg <= result_reg;
            end
         end
      end
   end

   // ==========================================================
   // Window comparator: alarm while enabled and result leaves window
   always @(posedge clk) begin
      if (!rst_n || soft_rst_reg || !window_compare_on) begin
         window_alarm_reg <= 1'b0;
      end else if (conv_done) begin
         window_alarm_reg <= (result_reg < window_low_i) || (result_reg > window_high_i);
      end
   end

   // ==========================================================
   // Mean-square over 16 results, kept cheap; no square root taken
   wire [23:0] rms_square = result_reg * result_reg;
   wire [27:0] rms_sum = rms_acc_reg + {4'h0, rms_square};

   // Publish on the sixteenth result so the sum covers all sixteen
   always @(posedge clk) begin
      if (!rst_n || soft_rst_reg) begin
         rms_acc_reg <= 28'h000_0000;
         rms_count_reg <= 5'h00;
         root_mean_square_value <= 16'h0000;
      end else if (wr_general && wbyte[`GEN_RMS]) begin
         rms_acc_reg <= 28'h000_0000;
         rms_count_reg <= 5'h00;
         root_mean_square_value <= 16'h0000;
      end else if (root_mean_square_on && conv_done) begin
         if (rms_count_reg == 5'h0f) begin
            root_mean_square_value <= rms_sum[27:12];
            rms_acc_reg <= 28'h000_0000;
            rms_count_reg <= 5'h00;
         end else begin
            rms_acc_reg <= rms_sum;
            rms_count_reg <= rms_count_reg + 5'h01;
         end
      end
   end

   // ==========================================================
   // Interrupt status: sticky events, write-one-to-clear, set wins
   wire [3:0] events;
   assign events[`EV_CONV] = conv_done;
   assign events[`EV_CAL] = cal_done;
   assign events[`EV_WINDOW] = window_alarm_reg;
   assign events[`EV_CRC] = crc_on & crc_error_i;

   wire [3:0] irq_clear = (wr && idx == `IDX_IRQ_CLEAR) ? wbyte[3:0] : 4'h0;

   always @(posedge clk) begin
      if (!rst_n || soft_rst_reg) begin
         irq_status_reg <= `RESET_IRQ;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clear) | events;
      end
   end

   assign irq = |(irq_status_reg & irq_enable_reg);

endmodule

/* verification/adc_cfg_monitor.sv */
// Assertion checker for the converter configuration bank, watching top ports only.
// Assumes a classic Wishbone master that holds its request until ack is sampled.
`timescale 1ns/1ps
`include "adc_cfg_consts.vh"
module adc_cfg_monitor (
   input wire clk,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire scl_o,
   input wire scl_oe,
   input wire crc_on,
   input wire force_analog_all,
   input wire calibrate_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Stretch length counter
   // Longest stretch is 128 samples of 200 cycles; a counter avoids a huge delay range
   logic [15:0] stretch_cnt;
   always @(posedge clk) begin
      if (!rst_n || !scl_oe)
         stretch_cnt <= 16'h0000;
      else
         stretch_cnt <= stretch_cnt + 16'h0001;
   end
   // ==========================================
   // Bus sequences
   sequence take_wr(logic [5:0] i);
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == i;
   endsequence
   sequence read_ack(logic [5:0] i);
      wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i[7:2] == i;
   endsequence
   // ==========================================
   // Properties
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_upper_zero: assert property (read_ack(`IDX_GENERAL) |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   a_crc_follow: assert property (take_wr(`IDX_GENERAL) |=> crc_on == $past(wb_dat_i[6]))
      else $error("check-code enable does not follow write");
   a_force_follow: assert property (
      take_wr(`IDX_GENERAL) |=> force_analog_all == $past(wb_dat_i[2]))
      else $error("force analog does not follow write");
   a_general_wo: assert property (
      read_ack(`IDX_GENERAL) |-> !wb_dat_o[3] && !wb_dat_o[0])
      else $error("write-only general bit reads one");
   a_format_rsvd: assert property (
      read_ack(`IDX_FORMAT) |-> !wb_dat_o[6] && wb_dat_o[3:0] == 4'h0)
      else $error("reserved format bits read nonzero");
   a_avg_rsvd: assert property (read_ack(`IDX_AVERAGING) |-> wb_dat_o[7:3] == 5'h00)
      else $error("reserved averaging bits read nonzero");
   a_stretch_low: assert property (scl_oe |-> !scl_o)
      else $error("stretch drives clock high");
   a_stretch_bound: assert property (stretch_cnt <= 16'd25700)
      else $error("clock stretch too long");
   a_cal_runs: assert property (
      take_wr(`IDX_GENERAL) ##0 (wb_dat_i[1] && !wb_dat_i[0]) |-> ##[1:2] calibrate_busy[*8])
      else $error("calibration did not start");
endmodule
bind adc_general_and_output_config adc_cfg_monitor u_mon (.clk(clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .scl_o(scl_o), .scl_oe(scl_oe), .crc_on(crc_on), .force_analog_all(force_analog_all),
   .calibrate_busy(calibrate_busy));

/* verification/adc_general_and_output_config_tb.sv */
// Self-checking bench for the converter configuration bank.
// Assumes one-cycle Wishbone answers and 200 cycles per converter sample.
`timescale 1ns/1ps
`include "adc_cfg_consts.vh"
module adc_general_and_output_config_tb;
   logic clk, rst_n, cyc, stb, we;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat;
   logic [11:0] sample;
   logic [15:0] rnd;
   logic [3:0] tag;
   wire [31:0] rdat;
   wire [15:0] conv_data;
   wire ack, scl_line, sda_line, scl_o, scl_oe, crc_on, force_all, cal_busy, irq;
   logic bo, cerr;
   int miscompares, comparisons, n;
   logic [7:0] expq[$];
   // ==========================================
   // Design and bus host
   adc_general_and_output_config uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl_line), .sda_i(sda_line), .scl_o(scl_o),
      .scl_oe(scl_oe), .brown_out_i(bo), .sample_i(sample), .channel_i(3'h5),
      .window_low_i(12'h000), .window_high_i(12'hfff), .crc_error_i(cerr), .crc_on(crc_on),
      .force_analog_all(force_all), .conv_data(conv_data), .calibrate_busy(cal_busy),
      .irq(irq));
   serial_host_model host (.scl_oe(scl_oe), .scl_o(scl_o), .scl_line(scl_line),
      .sda_line(sda_line));
   // ==========================================
   // Clock, helpers
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Classic single cycle; held until ack, then one idle cycle before the next
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
         input logic [7:0] exp = 8'h00);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h00_0000, d};
      if (!w)
         expq.push_back(exp);
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic wait_irq();
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      check("irq", irq, 1);
   endtask
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Read monitor: oldest noted value against the data returned with ack
   always @(posedge clk) begin
      if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
         check("read data", rdat, {24'h00_0000, expq.pop_front()});
   end
   // Watchdog: whole run is well under 20k cycles
   initial begin
      #400_000;
      miscompares++;
      close_out();
   end
   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h1;
      wdat = 32'h0000_0000; rnd = 16'd97; sample = 12'h000;
      bo = 1'b0;
      cerr = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, `IDX_GENERAL, 0); bus(0, `IDX_FORMAT, 0); bus(0, `IDX_AVERAGING, 0);
      bus(0, `IDX_POWER, 0, 8'h01); bus(1, `IDX_POWER, 8'h01); bus(0, `IDX_POWER, 0);
      bus(0, 6'h3f, 0);
      bus(1, `IDX_FORMAT, 8'hff); bus(0, `IDX_FORMAT, 0, 8'hb0);
      bus(1, `IDX_AVERAGING, 8'hff); bus(0, `IDX_AVERAGING, 0, 8'h07);
      bus(1, `IDX_GENERAL, 8'hf4); bus(0, `IDX_GENERAL, 0, 8'hf4);
      check("crc_on", crc_on, 1); check("force", force_all, 1);
      // Check-code error counts only while check codes are on
      cerr <= 1'b1;
      @(posedge clk);
      cerr <= 1'b0;
      bus(0, `IDX_IRQ_STATUS, 0, 8'h08);
      // Software reset clears everything and raises the power-loss flag
      bus(1, `IDX_GENERAL, 8'hff); bus(0, `IDX_GENERAL, 0); bus(0, `IDX_FORMAT, 0);
      bus(0, `IDX_AVERAGING, 0); bus(0, `IDX_POWER, 0, 8'h01);
      check("force", force_all, 0);
      bus(1, `IDX_IRQ_ENABLE, 8'h03);
      // Every tag mode with the fixed pattern; status tag sees only power loss
      for (int m = 0; m < 4; m++) begin
         rnd = lfsr(rnd);
         sample <= rnd[11:0];
         bus(1, `IDX_FORMAT, {2'b10, m[1:0], 4'h0});
         bus(1, `IDX_GENERAL, 8'h08);
         wait_irq();
         check("no stretch", scl_oe, 0);
         tag = (m == 1) ? 4'h5 : (m == 2) ? 4'h1 : 4'h0;
         check("pattern", conv_data, {12'ha5a, tag});
         bus(1, `IDX_IRQ_CLEAR, 8'h01);
         check("irq cleared", irq, 0);
      end
      // Masked event: status set, no interrupt; then real data through
      bus(1, `IDX_IRQ_ENABLE, 8'h00); bus(1, `IDX_FORMAT, 8'h00);
      rnd = lfsr(rnd);
      sample <= rnd[11:0];
      bus(1, `IDX_GENERAL, 8'h08);
      repeat (300) @(posedge clk);
      check("masked", irq, 0);
      bus(0, `IDX_IRQ_STATUS, 0, 8'h01);
      check("data", conv_data, {rnd[11:0], 4'h0});
      bus(0, `IDX_STAT_LATEST, 0);
      bus(1, `IDX_IRQ_CLEAR, 8'h0f); bus(1, `IDX_IRQ_ENABLE, 8'h02);
      // Calibration runs, self-clears and reports
      bus(1, `IDX_GENERAL, 8'h02); bus(0, `IDX_GENERAL, 0, 8'h02);
      check("cal busy", cal_busy, 1);
      wait_irq();
      bus(0, `IDX_GENERAL, 0); bus(0, `IDX_IRQ_STATUS, 0, 8'h02);
      // Brown-out sets the power-loss flag again after a clear
      bus(1, `IDX_POWER, 8'h01); bus(0, `IDX_POWER, 0);
      bo <= 1'b1;
      repeat (4) @(posedge clk);
      bo <= 1'b0;
      bus(0, `IDX_POWER, 0, 8'h01);
      // Statistics on with a trigger: latest and max follow the new result
      rnd = lfsr(rnd);
      sample <= {4'h0, rnd[7:0]};
      bus(1, `IDX_GENERAL, 8'h28);
      repeat (300) @(posedge clk);
      bus(0, `IDX_STAT_LATEST, 0, rnd[7:0]); bus(0, `IDX_STAT_MAX, 0, rnd[7:0]);
      // Bus frame with two-sample averaging: stretch covers both samples
      bus(1, `IDX_AVERAGING, 8'h01);
      fork
         host.frame(8'h91);
         begin
            n = 0;
            while (scl_oe !== 1'b1 && n < 1000) begin
               @(posedge clk);
               n++;
            end
            n = 0;
            while (scl_oe === 1'b1 && n < 1000) begin
               @(posedge clk);
               n++;
            end
            check("stretch", (n >= 400 && n <= 410), 1);
         end
      join
      close_out();
   end
endmodule

/* verification/serial_host_model.sv */
// Behavioural host on the two-wire bus: start, eight address bits, ack slot, stop.
// Assumes the device pulls the clock low only through scl_oe; both lines pulled up.
`timescale 1ns/1ps
module serial_host_model (
   input wire scl_oe,
   input wire scl_o,
   output wire scl_line,
   output logic sda_line
);
   logic scl_drv;
   // Wire level: host drive combined with the device's open-drain pull
   assign scl_line = scl_drv & ~(scl_oe & ~scl_o);
   // Idle: both lines released high, clock stands still between frames
   initial begin
      scl_drv = 1'b1;
      sda_line = 1'b1;
   end
   // One frame at an 80 ns bus clock; address and ack bits change only while the clock is low
   task automatic frame(input logic [7:0] addr);
      #1; // Keep line changes off the sampling clock edge
      sda_line = 1'b0;
      #40;
      for (int i = 0; i < 9; i++) begin
         scl_drv = 1'b0;
         sda_line = (i < 8) ? addr[7 - i] : 1'b1;
         #40;
         scl_drv = 1'b1;
         wait (scl_line === 1'b1);
         #40;
      end
      // Stop: data rises while the clock is high
      scl_drv = 1'b0;
      sda_line = 1'b0;
      #40;
      scl_drv = 1'b1;
      #40;
      sda_line = 1'b1;
   endtask
endmodule
